//--- core/control_pwm_timer_config.sv
// Control PWM timer: register bank, command synchronisation, waveform and event input A logic
`include "ctl_pwm_consts.svh"

module control_pwm_timer_config (
   input  wire logic       clk_sys_i,
   input  wire logic       rst_i,
   input  wire logic [5:0] reg_addr_i,
   input  wire logic [7:0] reg_wdata_i,
   input  wire logic       reg_wr_i,
   input  wire logic       reg_rd_i,
   output logic      [7:0] reg_rdata_o,
   input  wire logic       event_a_i,
   output logic            fault_a_o,
   output logic            wave_out_a_o,
   output logic            wave_out_b_o,
   output logic            wave_out_c_o,
   output logic            wave_out_d_o,
   output ctl_pwm_pkg::cycle_phase_t phase_o
);
   import ctl_pwm_pkg::*;

   // ----------------------------------------------------------------
   // Register bank
   // ----------------------------------------------------------------
   logic        enable_r;
   logic [1:0]  waveform_gen_select_r;
   logic [7:0]  routing_r;
   logic [7:0]  override_r;
   logic [7:0]  event_ctl_r;
   logic [11:0] cmp_buf_r [4];   // a_set, a_clr, b_set, b_clr, software side
   logic [11:0] cmp_act_r [4];   // timer side copies
   logic [11:0] capture_a_r;
   logic [11:0] capture_b_r;

   wire wr_enable   = reg_wr_i && reg_addr_i == `OFS_TIMER_ENABLE;
   wire wr_mode     = reg_wr_i && reg_addr_i == `OFS_WAVEFORM_MODE;
   wire wr_routing  = reg_wr_i && reg_addr_i == `OFS_OUTPUT_ROUTING;
   wire wr_override = reg_wr_i && reg_addr_i == `OFS_OVERRIDE_VALUES;
   wire wr_command  = reg_wr_i && reg_addr_i == `OFS_COMMAND_STROBES;
   wire wr_event    = reg_wr_i && reg_addr_i == `OFS_EVENT_A_CONTROL;
   wire wr_cmp      = reg_wr_i && reg_addr_i >= `OFS_CMP_A_SET_LOW && reg_addr_i <= `OFS_CMP_B_CLR_HIGH;
   wire [1:0] cmp_idx = reg_addr_i[2:1];
   wire       cmp_hi  = reg_addr_i[0];

   wire out_d_source      = routing_r[`BIT_OUT_D_SOURCE];
   wire out_c_source      = routing_r[`BIT_OUT_C_SOURCE];
   wire mirror_on         = routing_r[`BIT_MIRROR];
   wire auto_sync_request = routing_r[`BIT_AUTO_SYNC];
   wire output_override   = routing_r[`BIT_OVERRIDE];
   wire [3:0] override_levels_a = override_r[3:0];
   wire [3:0] override_levels_b = override_r[7:4];

   // B-side compare writes land in A as well when mirrored
   wire mirror_wr = wr_cmp && cmp_idx[1] && mirror_on;
   wire auto_sync_hit = reg_wr_i && auto_sync_request &&
                        (reg_addr_i == `OFS_CMP_B_CLR_HIGH ||
                         (mirror_on && reg_addr_i == `OFS_CMP_A_CLR_HIGH));

   // Byte write into one half of a 12-bit compare buffer
   function automatic logic [11:0] merge_byte(input logic [11:0] old, input logic hi, input logic [7:0] d);
      merge_byte = hi ? {d[3:0], old[7:0]} : {old[11:8], d};
   endfunction

   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         waveform_gen_select_r <= 2'h0;
         routing_r             <= `RST_CONTROL_BYTE;
         override_r            <= `RST_CONTROL_BYTE;
         event_ctl_r           <= `RST_CONTROL_BYTE;
      end else begin
         if (wr_mode) waveform_gen_select_r <= reg_wdata_i[1:0];
         if (wr_routing) routing_r <= reg_wdata_i & 8'hCB;
         if (wr_override) override_r <= reg_wdata_i;
         if (wr_event) event_ctl_r <= reg_wdata_i & 8'hD5;
      end
   end

   genvar gi;
   generate
      for (gi = 0; gi < 4; gi++) begin : g_cmp_buf
         always_ff @(posedge clk_sys_i) begin
            if (rst_i) begin
               cmp_buf_r[gi] <= `RST_COMPARE;
            end else if (wr_cmp && cmp_idx == 2'(gi)) begin
               cmp_buf_r[gi] <= merge_byte(cmp_buf_r[gi], cmp_hi, reg_wdata_i);
            end else if (mirror_wr && gi < 2 && cmp_idx[0] == 1'(gi)) begin
               cmp_buf_r[gi] <= merge_byte(cmp_buf_r[gi], cmp_hi, reg_wdata_i);
            end
         end
      end
   endgenerate

   // ----------------------------------------------------------------
   // Command and enable synchronisation
   // ----------------------------------------------------------------
   // The timer shares the system clock here; the crossing is kept as a fixed
   // latency so software sees the same ready handshake as on a split clock.
   logic [1:0] cmd_cnt_r;
   logic [4:0] cmd_bits_r;
   logic       command_ready_r;
   logic [1:0] en_cnt_r;
   logic       en_target_r;
   logic       enable_ready_r;
   logic       disable_pend_r;
   logic       eoc_sync_pend_r;
   logic       cycle_end;

   wire cmd_busy    = cmd_cnt_r != 2'h0;
   wire en_busy     = en_cnt_r != 2'h0;
   wire [4:0] cmd_in = reg_wdata_i[4:0];
   wire cmd_accept  = wr_command && cmd_in != 5'h00 && !cmd_busy;
   wire auto_accept = auto_sync_hit && !cmd_busy && !cmd_accept;
   wire cmd_fire    = cmd_cnt_r == 2'h1;
   wire en_fire     = en_cnt_r == 2'h1;
   wire dis_accept  = wr_command && reg_wdata_i[`BIT_DISABLE_EOC] && !en_busy && enable_r;
   wire en_accept   = wr_enable && !en_busy && !disable_pend_r;

   wire fire_cap_b  = cmd_fire && cmd_bits_r[`BIT_SOFT_CAPTURE_B];
   wire fire_cap_a  = cmd_fire && cmd_bits_r[`BIT_SOFT_CAPTURE_A];
   wire fire_rst    = cmd_fire && cmd_bits_r[`BIT_RESTART];
   wire fire_sync   = cmd_fire && cmd_bits_r[`BIT_SYNC_NOW];
   wire fire_eoc    = cmd_fire && cmd_bits_r[`BIT_SYNC_EOC];

   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         cmd_cnt_r       <= 2'h0;
         cmd_bits_r      <= 5'h00;
         command_ready_r <= 1'b1;
      end else if (cmd_accept || auto_accept) begin
         cmd_cnt_r       <= `SYNC_CYCLES;
         cmd_bits_r      <= cmd_accept ? cmd_in : 5'h01;
         command_ready_r <= 1'b0;
      end else if (cmd_busy) begin
         cmd_cnt_r       <= cmd_cnt_r - 2'h1;
         command_ready_r <= cmd_fire;
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         en_cnt_r       <= 2'h0;
         en_target_r    <= 1'b0;
         enable_r       <= 1'b0;
         enable_ready_r <= 1'b1;
         disable_pend_r <= 1'b0;
      end else if (en_accept) begin
         en_cnt_r       <= `SYNC_CYCLES;
         en_target_r    <= reg_wdata_i[0];
         enable_ready_r <= 1'b0;
      end else if (en_busy) begin
         en_cnt_r <= en_cnt_r - 2'h1;
         if (en_fire) begin
            enable_r       <= en_target_r;
            enable_ready_r <= 1'b1;
         end
      end else if (dis_accept) begin
         disable_pend_r <= 1'b1;
         enable_ready_r <= 1'b0;
      end else if (disable_pend_r && cycle_end) begin
         disable_pend_r <= 1'b0;
         enable_r       <= 1'b0;
         enable_ready_r <= 1'b1;
      end
   end

   // ----------------------------------------------------------------
   // Double-buffer loading
   // ----------------------------------------------------------------
   wire load_now = fire_sync || (eoc_sync_pend_r && cycle_end);

   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         eoc_sync_pend_r <= 1'b0;
      end else if (fire_eoc) begin
         eoc_sync_pend_r <= 1'b1;
      end else if (cycle_end) begin
         eoc_sync_pend_r <= 1'b0;
      end
   end

   generate
      for (gi = 0; gi < 4; gi++) begin : g_cmp_act
         always_ff @(posedge clk_sys_i) begin
            if (rst_i) begin
               cmp_act_r[gi] <= `RST_COMPARE;
            end else if (load_now) begin
               cmp_act_r[gi] <= cmp_buf_r[gi];
            end
         end
      end
   endgenerate

   // ----------------------------------------------------------------
   // Counter and cycle phases
   // ----------------------------------------------------------------
   logic [11:0] cnt_r;
   logic [1:0]  ramp_r;      // Ramp index within a cycle, or 1 while counting down
   wave_mode_t  mode;
   logic [11:0] ramp_top;
   logic        ramp_last;
   logic        a_on;
   logic        b_on;
   cycle_phase_t phase;

   wire [11:0] a_set = cmp_act_r[0];
   wire [11:0] a_clr = cmp_act_r[1];
   wire [11:0] b_set = cmp_act_r[2];
   wire [11:0] b_clr = cmp_act_r[3];

   always_comb begin
      mode      = wave_mode_t'(waveform_gen_select_r);
      ramp_top  = b_clr;
      ramp_last = 1'b1;
      a_on      = 1'b0;
      b_on      = 1'b0;
      case (mode)
         single_ramp: begin
            a_on = cnt_r >= a_set && cnt_r < a_clr;
            b_on = cnt_r >= b_set && cnt_r < b_clr;
         end
         double_ramp: begin
            ramp_top  = ramp_r[0] ? b_clr : a_clr;
            ramp_last = ramp_r[0];
            a_on      = !ramp_r[0] && cnt_r >= a_set;
            b_on      = ramp_r[0] && cnt_r >= b_set;
         end
         quad_ramp: begin
            ramp_top  = cmp_act_r[ramp_r];
            ramp_last = ramp_r == 2'h3;
            a_on      = ramp_r == 2'h1;
            b_on      = ramp_r == 2'h3;
         end
         up_down_slope: begin
            ramp_last = ramp_r[0] && cnt_r == 12'h000;
            a_on      = cnt_r < a_clr;
            b_on      = cnt_r > b_set;
         end
         default: begin
            a_on = 1'b0;
         end
      endcase
   end

   wire at_top = mode == up_down_slope ? (ramp_r[0] ? cnt_r == 12'h000 : cnt_r >= ramp_top) : cnt_r >= ramp_top;
   assign cycle_end = enable_r && at_top && ramp_last;

   always_comb begin
      if (a_on) begin
         phase = ph_on_time_a;
      end else if (b_on) begin
         phase = ph_on_time_b;
      end else if (mode == single_ramp ? cnt_r < a_clr : !ramp_r[0] && ramp_r != 2'h2) begin
         phase = ph_dead_time_a;
      end else begin
         phase = ph_dead_time_b;
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (rst_i || fire_rst || !enable_r) begin
         cnt_r  <= 12'h000;
         ramp_r <= 2'h0;
      end else if (mode == up_down_slope) begin
         if (at_top) begin
            ramp_r <= {1'b0, !ramp_r[0]};
         end
         cnt_r <= (ramp_r[0] ^ at_top) ? cnt_r - 12'h001 : cnt_r + 12'h001;
      end else if (at_top) begin
         cnt_r  <= 12'h000;
         ramp_r <= ramp_last ? 2'h0 : ramp_r + 2'h1;
      end else begin
         cnt_r <= cnt_r + 12'h001;
      end
   end

   // ----------------------------------------------------------------
   // Event input A
   // ----------------------------------------------------------------
   logic [`FILTER_SAMPLES-2:0] ev_hist_r;
   logic                       ev_filt_r;
   logic                       ev_prev_r;

   wire [1:0] ev_cfg_raw   = event_ctl_r[7:6];
   wire       ev_edge_high = event_ctl_r[`BIT_EVENT_EDGE];
   wire       ev_capture   = event_ctl_r[`BIT_EVENT_ACTION];
   wire       ev_trigger   = event_ctl_r[`BIT_EVENT_TRIGGER];
   wire       noise_filter_on = ev_cfg_raw == cfg_noise_filter_on;
   wire       async_event_on  = ev_cfg_raw == cfg_async_event_on;
   wire       ev_all_equal    = &{ev_hist_r, event_a_i} || ~|{ev_hist_r, event_a_i};
   wire       ev_level        = noise_filter_on ? ev_filt_r : event_a_i;
   wire       ev_active       = ev_level == ev_edge_high;
   wire       ev_capture_hit  = ev_trigger && ev_capture && ev_active && ev_prev_r != ev_edge_high;
   logic      fault_r;

   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         ev_hist_r <= '0;
         ev_filt_r <= 1'b0;
         ev_prev_r <= 1'b0;
         fault_r   <= 1'b0;
      end else begin
         ev_hist_r <= {ev_hist_r[`FILTER_SAMPLES-3:0], event_a_i};
         if (ev_all_equal) ev_filt_r <= event_a_i;
         ev_prev_r <= ev_level;
         fault_r   <= ev_trigger && ev_active;
      end
   end

   // Async mode bypasses the flop so a fault reaches the switches without clock latency
   wire fault_now = ev_trigger && ev_active;
   assign fault_a_o = async_event_on ? fault_now : fault_r;

   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         capture_a_r <= `RST_COMPARE;
         capture_b_r <= `RST_COMPARE;
      end else begin
         if (fire_cap_a || ev_capture_hit) capture_a_r <= cnt_r;
         if (fire_cap_b) capture_b_r <= cnt_r;
      end
   end

   // ----------------------------------------------------------------
   // Waveform outputs
   // ----------------------------------------------------------------
   logic wave_a;
   logic wave_b;

   always_comb begin
      wave_a = a_on;
      wave_b = b_on;
      if (output_override) begin
         if (mode == single_ramp) begin
            wave_a = a_on ? override_levels_a[0] : override_levels_a[1];
            wave_b = b_on ? override_levels_b[2] : override_levels_b[3];
         end else begin
            case (phase)
               ph_dead_time_a: begin
                  wave_a = override_levels_a[0];
                  wave_b = override_levels_b[0];
               end
               ph_on_time_a: begin
                  wave_a = override_levels_a[1];
                  wave_b = override_levels_b[1];
               end
               ph_dead_time_b: begin
                  wave_a = override_levels_a[2];
                  wave_b = override_levels_b[2];
               end
               default: begin
                  wave_a = override_levels_a[3];
                  wave_b = override_levels_b[3];
               end
            endcase
         end
      end
   end

   // A stopped timer parks every output low; fault handling lives outside
   always_ff @(posedge clk_sys_i) begin
      if (rst_i || !enable_r) begin
         wave_out_a_o <= 1'b0;
         wave_out_b_o <= 1'b0;
         wave_out_c_o <= 1'b0;
         wave_out_d_o <= 1'b0;
         phase_o      <= ph_dead_time_a;
      end else begin
         wave_out_a_o <= wave_a;
         wave_out_b_o <= wave_b;
         wave_out_c_o <= out_c_source ? wave_b : wave_a;
         wave_out_d_o <= out_d_source ? wave_b : wave_a;
         phase_o      <= phase;
      end
   end

   // ----------------------------------------------------------------
   // Read port
   // ----------------------------------------------------------------
   logic [7:0] rd_mux;

   always_comb begin
      case (reg_addr_i)
         `OFS_TIMER_ENABLE:    rd_mux = {7'h00, enable_r};
         `OFS_WAVEFORM_MODE:   rd_mux = {6'h00, waveform_gen_select_r};
         `OFS_OUTPUT_ROUTING:  rd_mux = routing_r;
         `OFS_OVERRIDE_VALUES: rd_mux = override_r;
         `OFS_EVENT_A_CONTROL: rd_mux = event_ctl_r;
         `OFS_TIMER_STATUS:    rd_mux = {6'h00, command_ready_r, enable_ready_r};
         `OFS_CAPTURE_A_LOW:   rd_mux = capture_a_r[7:0];
         `OFS_CAPTURE_A_HIGH:  rd_mux = {4'h0, capture_a_r[11:8]};
         `OFS_CAPTURE_B_LOW:   rd_mux = capture_b_r[7:0];
         `OFS_CAPTURE_B_HIGH:  rd_mux = {4'h0, capture_b_r[11:8]};
         default: begin
            if (reg_addr_i >= `OFS_CMP_A_SET_LOW && reg_addr_i <= `OFS_CMP_B_CLR_HIGH) begin
               rd_mux = cmp_hi ? {4'h0, cmp_buf_r[cmp_idx][11:8]} : cmp_buf_r[cmp_idx][7:0];
            end else begin
               rd_mux = 8'h00;
            end
         end
      endcase
   end

   always_ff @(posedge clk_sys_i) begin
      if (rst_i || !reg_rd_i) begin
         reg_rdata_o <= 8'h00;
      end else begin
         reg_rdata_o <= rd_mux;
      end
   end
endmodule // control_pwm_timer_config

//--- core/ctl_pwm_consts.svh
// Offsets, field positions, reset values and counts of the control PWM timer register bank
`ifndef CTL_PWM_CONSTS_SVH
`define CTL_PWM_CONSTS_SVH
// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define OFS_TIMER_ENABLE       6'h00
`define OFS_WAVEFORM_MODE      6'h01
`define OFS_OUTPUT_ROUTING     6'h02
`define OFS_OVERRIDE_VALUES    6'h03
`define OFS_COMMAND_STROBES    6'h04
`define OFS_EVENT_A_CONTROL    6'h08
`define OFS_TIMER_STATUS       6'h0E
`define OFS_CAPTURE_A_LOW      6'h22
`define OFS_CAPTURE_A_HIGH     6'h23
`define OFS_CAPTURE_B_LOW      6'h24
`define OFS_CAPTURE_B_HIGH     6'h25
`define OFS_CMP_A_SET_LOW      6'h28
`define OFS_CMP_A_CLR_HIGH     6'h2B
`define OFS_CMP_B_SET_LOW      6'h2C
`define OFS_CMP_B_CLR_HIGH     6'h2F
// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define BIT_OUT_D_SOURCE       7
`define BIT_OUT_C_SOURCE       6
`define BIT_MIRROR             3
`define BIT_AUTO_SYNC          1
`define BIT_OVERRIDE           0
`define BIT_DISABLE_EOC        7
`define BIT_SOFT_CAPTURE_B     4
`define BIT_SOFT_CAPTURE_A     3
`define BIT_RESTART            2
`define BIT_SYNC_NOW           1
`define BIT_SYNC_EOC           0
`define BIT_EVENT_EDGE         4
`define BIT_EVENT_ACTION       2
`define BIT_EVENT_TRIGGER      0
`define BIT_COMMAND_READY      1
`define BIT_ENABLE_READY       0
// ----------------------------------------------------------------
// Reset values and counts
// ----------------------------------------------------------------
`define RST_CONTROL_BYTE       8'h00
`define RST_COMPARE            12'h000
`define SYNC_CYCLES            2'h2
`define FILTER_SAMPLES         4
`endif

//--- core/ctl_pwm_pkg.sv
// Types shared by the control PWM timer configuration logic
package ctl_pwm_pkg;
   typedef enum logic [1:0] {
      single_ramp   = 2'h0,
      double_ramp   = 2'h1,
      quad_ramp     = 2'h2,
      up_down_slope = 2'h3
   } wave_mode_t;

   typedef enum logic [1:0] {
      cfg_neither         = 2'h0,
      cfg_noise_filter_on = 2'h1,
      cfg_async_event_on  = 2'h2
   } event_cfg_t;

   // Gray order along the normal cycle: dead A, on A, dead B, on B
   typedef enum logic [1:0] {
      ph_dead_time_a = 2'b00,
      ph_on_time_a   = 2'b01,
      ph_dead_time_b = 2'b11,
      ph_on_time_b   = 2'b10
   } cycle_phase_t;
endpackage : ctl_pwm_pkg

//--- verification/ctl_pwm_sva.sv
// Concurrent checks on the control PWM timer ports
module ctl_pwm_sva
   import ctl_pwm_pkg::*;
(
   input wire logic         clk_sys_i,
   input wire logic         rst_i,
   input wire logic [5:0]   reg_addr_i,
   input wire logic [7:0]   reg_wdata_i,
   input wire logic         reg_wr_i,
   input wire logic         reg_rd_i,
   input wire logic [7:0]   reg_rdata_o,
   input wire logic         event_a_i,
   input wire logic         fault_a_o,
   input wire logic         wave_out_a_o,
   input wire logic         wave_out_b_o,
   input wire logic         wave_out_c_o,
   input wire logic         wave_out_d_o,
   input wire cycle_phase_t phase_o
);
   timeunit 1ns;
   timeprecision 1ps;
   logic       en_r;
   logic [7:0] mode_r, route_r, ovr_r, ev_r;
   logic [3:0] q_r;
   // Shadows are trusted only after a quiet spell, so sync latency never matters
   wire        settled = (q_r == 4'hf);
   wire  [1:0] idx     = {phase_o[1], ^phase_o};
   always_ff @(posedge clk_sys_i) begin
      q_r <= (rst_i || reg_wr_i) ? 4'h0 : (settled ? q_r : q_r + 4'h1);
      if (rst_i) {en_r, mode_r, route_r, ovr_r, ev_r} <= '0;
      else if (reg_wr_i && reg_addr_i == 6'h00) en_r <= reg_wdata_i[0];
      else if (reg_wr_i && reg_addr_i == 6'h01) mode_r <= reg_wdata_i;
      else if (reg_wr_i && reg_addr_i == 6'h02) route_r <= reg_wdata_i;
      else if (reg_wr_i && reg_addr_i == 6'h03) ovr_r <= reg_wdata_i;
      else if (reg_wr_i && reg_addr_i == 6'h08) ev_r <= reg_wdata_i;
   end
   default clocking @(posedge clk_sys_i); endclocking
   default disable iff (rst_i);
   sequence s_calm;
      settled && $stable(wave_out_a_o) && $stable(wave_out_b_o);
   endsequence
   sequence s_ovr;
      settled && en_r && route_r[0] && $stable(phase_o);
   endsequence
   a_rdata_quiet: assert property (!$past(reg_rd_i) |-> reg_rdata_o == 8'h00) else $error("read data outside slot");
   a_out_c_route: assert property (s_calm |-> wave_out_c_o == (route_r[6] ? wave_out_b_o : wave_out_a_o))
      else $error("output C source wrong");
   a_out_d_route: assert property (s_calm |-> wave_out_d_o == (route_r[7] ? wave_out_b_o : wave_out_a_o))
      else $error("output D source wrong");
   a_wave_idle: assert property (settled && !en_r |-> !wave_out_a_o && !wave_out_b_o) else $error("wave while off");
   a_ovr_one_a: assert property (s_ovr ##0 (mode_r[1:0] == 2'h0 && !phase_o[1]) |-> wave_out_a_o == ovr_r[!phase_o[0]])
      else $error("one ramp A level wrong");
   a_ovr_one_b: assert property (s_ovr ##0 (mode_r[1:0] == 2'h0 && phase_o[1]) |-> wave_out_b_o == ovr_r[6 + phase_o[0]])
      else $error("one ramp B level wrong");
   a_ovr_multi_a: assert property (s_ovr ##0 (mode_r[1:0] inside {2'h1, 2'h2}) |-> wave_out_a_o == ovr_r[idx])
      else $error("ramp A level wrong");
   a_ovr_multi_b: assert property (s_ovr ##0 (mode_r[1:0] inside {2'h1, 2'h2}) |-> wave_out_b_o == ovr_r[4 + idx])
      else $error("ramp B level wrong");
   a_async_fault: assert property (settled && ev_r[7:6] == 2'h2 && ev_r[0] |-> fault_a_o == (event_a_i == ev_r[4]))
      else $error("async fault level wrong");
endmodule // ctl_pwm_sva

//--- verification/pwm_load_model.sv
// Load on routed output C: counts switch-on events
module pwm_load_model (
   input  wire logic        clk_sys_i,
   input  wire logic        wave_c_i,
   output logic      [15:0] edges_o
);
   timeunit 1ns;
   timeprecision 1ps;
   logic c_r = 1'b0;
   initial edges_o = 16'h0000;
   always @(posedge clk_sys_i) begin
      c_r <= wave_c_i;
      if (wave_c_i && !c_r) edges_o <= edges_o + 16'h0001;
   end
endmodule // pwm_load_model

//--- verification/testbench.sv
// Self-checking bench for the control PWM timer configuration block
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   import ctl_pwm_pkg::*;
   logic clk_sys_i = 1'b0, rst_i = 1'b1, reg_wr_i = 1'b0, reg_rd_i = 1'b0, event_a_i = 1'b0, rd_d = 1'b0;
   logic [5:0] reg_addr_i = 6'h00;
   logic [7:0] reg_wdata_i = 8'h00, reg_rdata_o, d, exp_q[$];
   logic fault_a_o, wave_out_a_o, wave_out_b_o, wave_out_c_o, wave_out_d_o, ev_old;
   logic [15:0] edges;
   cycle_phase_t phase_o;
   int error_cnt = 0, samples_checked = 0, cyc = 0, t = 0;
   control_pwm_timer_config control_pwm_timer_config_i (.clk_sys_i, .rst_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i,
      .reg_rd_i, .reg_rdata_o, .event_a_i, .fault_a_o, .wave_out_a_o, .wave_out_b_o, .wave_out_c_o, .wave_out_d_o, .phase_o);
   pwm_load_model pwm_load_model_i (.clk_sys_i, .wave_c_i(wave_out_c_o), .edges_o(edges));
   initial forever #2.5 clk_sys_i = ~clk_sys_i;
   task summarize;
      $display("checks %0d mismatches %0d load edges %0d", samples_checked, error_cnt, edges);
      if (error_cnt == 0 && samples_checked > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   task chk(input logic [7:0] got, input logic [7:0] exp);
      samples_checked++;
      if (got !== exp) begin
         error_cnt++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // One bus cycle; a read queues its expected data for the watcher
   task bus(input logic w, input logic [5:0] a, input logic [7:0] v);
      @(posedge clk_sys_i);
      reg_wr_i <= w;
      reg_rd_i <= !w;
      reg_addr_i <= a;
      reg_wdata_i <= v;
      if (!w) exp_q.push_back(v);
      @(posedge clk_sys_i);
      reg_wr_i <= 1'b0;
      reg_rd_i <= 1'b0;
   endtask
   task done;
      t++;
      $display("test %0d finished", t);
   endtask
   always @(posedge clk_sys_i) begin
      if (rd_d) chk(reg_rdata_o, exp_q.pop_front());
      rd_d <= reg_rd_i;
      event_a_i <= $urandom;
      // Level the design sampled at this edge, for the registered fault path
      ev_old <= event_a_i;
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         error_cnt++;
         summarize();
      end
   end
   initial begin
      void'($urandom(32'hded7));
      repeat (5) @(posedge clk_sys_i);
      rst_i <= 1'b0;
      for (int i = 1; i < 9; i++) if (i < 5 || i == 8) bus(0, i[5:0], 8'h00);
      bus(0, 6'h0E, 8'h03);
      bus(0, 6'h3F, 8'h00);
      bus(1, 6'h02, 8'hFF);
      bus(0, 6'h02, 8'hCB);
      bus(1, 6'h08, 8'hFF);
      bus(0, 6'h08, 8'hD5);
      done();
      bus(1, 6'h04, 8'h08);
      bus(0, 6'h0E, 8'h01);
      repeat (4) @(posedge clk_sys_i);
      bus(0, 6'h0E, 8'h03);
      bus(1, 6'h00, 8'h01);
      bus(0, 6'h0E, 8'h02);
      bus(1, 6'h04, 8'h02);
      bus(0, 6'h0E, 8'h01);
      done();
      d = $urandom;
      bus(1, 6'h02, 8'h0B);
      bus(1, 6'h2C, d);
      bus(0, 6'h28, d);
      bus(1, 6'h2E, 8'h20);
      bus(1, 6'h2F, 8'h00);
      bus(0, 6'h0E, 8'h01);
      bus(0, 6'h2A, 8'h20);
      repeat (80) @(posedge clk_sys_i);
      bus(1, 6'h2B, 8'h00);
      bus(0, 6'h0E, 8'h01);
      repeat (80) @(posedge clk_sys_i);
      bus(0, 6'h0E, 8'h03);
      done();
      bus(1, 6'h08, 8'h55);
      for (int m = 0; m < 16; m++) begin
         bus(1, 6'h01, {6'h00, m[1:0]});
         bus(1, 6'h02, {m[3:2], 6'h09});
         bus(1, 6'h03, $urandom);
         repeat (100) @(posedge clk_sys_i);
      end
      done();
      // Plain then async configuration, each edge polarity, trigger enabled
      for (int e = 0; e < 4; e++) begin
         bus(1, 6'h08, {e[1], 2'h0, e[0], 4'h1});
         @(posedge clk_sys_i);
         repeat (20) begin
            @(negedge clk_sys_i);
            chk({7'h00, fault_a_o}, {7'h00, (e[1] ? event_a_i : ev_old) ~^ e[0]});
         end
      end
      // Start the disable at the top of the slope, far from the cycle end
      @(posedge clk_sys_i iff phase_o != ph_on_time_a);
      bus(1, 6'h04, 8'h80);
      bus(0, 6'h0E, 8'h02);
      repeat (80) @(posedge clk_sys_i);
      bus(0, 6'h0E, 8'h03);
      repeat (3) @(posedge clk_sys_i);
      done();
      summarize();
   end
endmodule // testbench
bind control_pwm_timer_config ctl_pwm_sva ctl_pwm_sva_i (.clk_sys_i, .rst_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i,
   .reg_rd_i, .reg_rdata_o, .event_a_i, .fault_a_o, .wave_out_a_o, .wave_out_b_o, .wave_out_c_o, .wave_out_d_o, .phase_o);
